// File: core/sdac_pkg.sv
// package: register map, field layout and encodings of the converter control
// ----------------------------------------------------------------------------
// Functional notes
// - result is 16-bit read-only, 14 bits left-aligned
// - result undefined while a conversion runs
// - repeat_select 1 converts regardless of trigger
// - 3-bit divider: 1,2,4,8,16,32; 11x prohibited
// - reference field sets shared pin role
// - code 11 feeds generator and drives pin together
// - gain field: 1, 2, 4, one third
// - single-shot trigger write starts one conversion
// - completion loads result, sets flag, enable gates irq; an end on the count alone keeps the old result
// - active flag high during single-shot, auto-cleared; a control write with repeat_select 0 in the final cycle leaves it set
// - repeating stops on mode clear, reset, low power
// ----------------------------------------------------------------------------
package sdac_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [15:0] SDAC_ADDR_CTRL   = 16'hf060; // converter_control
  localparam logic [15:0] SDAC_ADDR_START  = 16'hf061; // start_status_control
  localparam logic [15:0] SDAC_ADDR_RESULT = 16'hf062; // conversion_result
  localparam logic [15:0] SDAC_ADDR_IRQ_ST = 16'hf064; // sticky status
  localparam logic [15:0] SDAC_ADDR_IRQ_MK = 16'hf065; // interrupt mask
  localparam logic [15:0] SDAC_ADDR_BGR    = 16'hf066; // bandgap_control

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int SDAC_CTRL_MODE_BIT   = 7;  // repeat_select
  localparam int SDAC_START_TRIG_BIT  = 7;  // single_conversion_trigger
  localparam int SDAC_START_ACT_BIT   = 6;  // conversion_active_flag
  localparam int SDAC_RES_LSB         = 2;  // result_lsb position
  localparam int SDAC_RES_W           = 14; // result width

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] SDAC_CTRL_RST  = 8'h04; // ref field 01
  localparam logic [5:0] SDAC_START_RST = 6'h1c; // chan 01, bypass 1
  localparam logic [1:0] SDAC_MASK_RST  = 2'h1;  // end irq enabled

  // ------------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------------
  localparam logic [1:0] SDAC_REF_PORT = 2'h0; // shared pin is port input
  localparam logic [1:0] SDAC_REF_EXT  = 2'h1; // external reference
  localparam logic [1:0] SDAC_REF_OUT  = 2'h2; // band-gap out only
  localparam logic [1:0] SDAC_REF_BOTH = 2'h3; // band-gap out and feed
  localparam logic [2:0] SDAC_DIV_MAX  = 3'h5; // divide by 32
  localparam int         SDAC_OVS_PER_CONV = 320; // oversamples per result

  // control register layout
  typedef struct packed {
    logic       repeat_select; // single 0, repeating 1
    logic [2:0] oversample_div;// divider code
    logic [1:0] reference_sel; // shared pin role
    logic [1:0] gain_sel;      // amplifier gain code
  } sdac_ctrl_t;

  // analog-side controls
  typedef struct packed {
    logic       shared_pin_oe;   // drive band-gap onto shared pin
    logic       ext_ref_sel;     // external reference to generator
    logic       int_ref_sel;     // internal reference to generator
    logic       pin_is_port;     // pin acts as port input
    logic [1:0] gain_sel;        // gain code to amplifier
    logic [1:0] channel_sel;     // analog input channel
    logic       gain_bypass;     // amplifier bypass
    logic       modulator_run;   // modulator sampling enabled
  } sdac_analog_t;

  // state machine
  typedef enum logic [1:0] {SDAC_IDLE, SDAC_CONV} sdac_state_t;

endpackage

// File: core/sdac_core.sv
// module: sigma-delta converter control, registers and conversion sequencing
`timescale 1ns/1ps
module sdac_core #(
  parameter int CONV_OVS = 320 // oversample ticks per conversion
) (
  input  wire  logic                clk_sys,        // system clock 25 MHz
  input  wire  logic                rst,            // sync, active high
  input  wire  logic [15:0]         reg_addr,       // register address
  input  wire  logic [15:0]         reg_wdata,      // write data
  input  wire  logic                reg_wr,         // write strobe
  input  wire  logic                reg_rd,         // read strobe
  output logic       [15:0]         reg_rdata,      // read data, next cycle
  input  wire  logic                low_power,      // low-power entry
  input  wire  logic                filter_valid,   // decimator word ready
  input  wire  logic [13:0]         filter_data,    // decimator word
  output sdac_pkg::sdac_analog_t    analog_ctrl,    // analog controls
  output logic                      ovs_tick,       // oversample enable
  output logic                      irq             // level interrupt
);
  import sdac_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    sdac_ctrl_t   ctrl;       // converter_control
    logic [5:0]   start;      // channel, bypass and spare bits
    logic         active;     // conversion_active_flag
    logic [13:0]  result;     // result word
    logic [1:0]   irq_st;     // sticky: 0 end, 1 bad divider
    logic [1:0]   irq_mk;     // mask
    logic         bg_run;     // bandgap_run
    sdac_state_t  state;      // sequencer
    logic [4:0]   div_cnt;    // oversample divider
    logic [8:0]   ovs_cnt;    // ticks in this conversion
    logic         tick;       // registered divider tick
    logic [15:0]  rdata;      // read data register
  } sdac_regs_t;

  sdac_regs_t cur_ff;  // registered state
  sdac_regs_t nxt_cur; // next state

  // divider ratio decode, used by the divider only
  function automatic logic [4:0] div_limit(input logic [2:0] code);
    div_limit = 5'h1f >> (SDAC_DIV_MAX - code); // 2**code - 1
  endfunction

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    logic done;  // conversion ends this cycle
    logic trig;  // single-shot trigger written
    nxt_cur = cur_ff;
    done = 1'b0;
    trig = 1'b0;
    nxt_cur.tick = 1'b0;
    // oversample divider; 11x clamps to /32 to keep the modulator sane
    if (cur_ff.state == SDAC_CONV) begin
      if (cur_ff.div_cnt >= div_limit((cur_ff.ctrl.oversample_div >
          SDAC_DIV_MAX) ? SDAC_DIV_MAX : cur_ff.ctrl.oversample_div)) begin
        nxt_cur.div_cnt = 5'h00;
        nxt_cur.tick = 1'b1;
      end else begin
        nxt_cur.div_cnt = cur_ff.div_cnt + 5'h01;
      end
    end else begin
      nxt_cur.div_cnt = 5'h00;
    end
    // count ticks; the decimator word marks the end, or the count
    if (cur_ff.tick) begin
      nxt_cur.ovs_cnt = cur_ff.ovs_cnt + 9'h001;
    end
    if (cur_ff.state == SDAC_CONV && (filter_valid ||
        (cur_ff.tick && cur_ff.ovs_cnt == 9'(CONV_OVS - 1)))) begin
      done = 1'b1;
    end
    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        SDAC_ADDR_CTRL: begin
          nxt_cur.ctrl = sdac_ctrl_t'(reg_wdata[7:0]);
        end
        SDAC_ADDR_START: begin
          nxt_cur.start = reg_wdata[5:0];
          trig = reg_wdata[SDAC_START_TRIG_BIT];
        end
        SDAC_ADDR_IRQ_ST: begin
          nxt_cur.irq_st = cur_ff.irq_st & ~reg_wdata[1:0]; // w1c
        end
        SDAC_ADDR_IRQ_MK: begin
          nxt_cur.irq_mk = reg_wdata[1:0];
        end
        SDAC_ADDR_BGR: begin
          nxt_cur.bg_run = reg_wdata[0];
        end
        default: begin
          // result is read-only, lsbs ignored; others unmapped
        end
      endcase
    end
    // prohibited divider code flagged as an event
    if (cur_ff.ctrl.oversample_div > SDAC_DIV_MAX) begin
      nxt_cur.irq_st[1] = 1'b1;
    end
    // sequencer
    unique case (cur_ff.state)
      SDAC_IDLE: begin
        if (cur_ff.ctrl.repeat_select || trig) begin
          nxt_cur.state = SDAC_CONV;
          nxt_cur.active = 1'b1;
          nxt_cur.ovs_cnt = 9'h000;
        end
      end
      SDAC_CONV: begin
        if (done) begin
          nxt_cur.result = filter_valid ? filter_data : cur_ff.result;
          nxt_cur.irq_st[0] = 1'b1;
          nxt_cur.ovs_cnt = 9'h000;
          if (!cur_ff.ctrl.repeat_select) begin
            nxt_cur.state = SDAC_IDLE;
            nxt_cur.active = 1'b0;
          end
        end
      end
    endcase
    // low power ends the run at once; mode clear ends it after the current conversion
    if (low_power || (cur_ff.state == SDAC_CONV && !done &&
        !cur_ff.ctrl.repeat_select && !cur_ff.active)) begin
      nxt_cur.state = SDAC_IDLE;
      nxt_cur.active = 1'b0;
    end
    if (cur_ff.state == SDAC_CONV && cur_ff.active &&
        !cur_ff.ctrl.repeat_select && reg_wr && reg_addr == SDAC_ADDR_CTRL &&
        !reg_wdata[SDAC_CTRL_MODE_BIT] && !trig) begin
      nxt_cur.active = cur_ff.active; // active flag held, even when the single-shot ends this cycle
    end
    // read mux, answered one cycle later
    nxt_cur.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        SDAC_ADDR_CTRL:   nxt_cur.rdata = {8'h00, cur_ff.ctrl};
        SDAC_ADDR_START:  nxt_cur.rdata = {8'h00, 1'b0, cur_ff.active,
                                           cur_ff.start};
        // bits 1:0 read zero; value mid-conversion is not meaningful
        SDAC_ADDR_RESULT: nxt_cur.rdata = {cur_ff.result, 2'h0};
        SDAC_ADDR_IRQ_ST: nxt_cur.rdata = {14'h0000, cur_ff.irq_st};
        SDAC_ADDR_IRQ_MK: nxt_cur.rdata = {14'h0000, cur_ff.irq_mk};
        SDAC_ADDR_BGR:    nxt_cur.rdata = {15'h0000, cur_ff.bg_run};
        default:          nxt_cur.rdata = 16'h0000; // unmapped reads zero
      endcase
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur_ff        <= '0;           // also stops repeating runs
      cur_ff.ctrl   <= sdac_ctrl_t'(SDAC_CTRL_RST);
      cur_ff.start  <= SDAC_START_RST;
      cur_ff.irq_mk <= SDAC_MASK_RST;
      cur_ff.state  <= SDAC_IDLE;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign reg_rdata = cur_ff.rdata;
  assign ovs_tick  = cur_ff.tick;
  assign irq       = |(cur_ff.irq_st & cur_ff.irq_mk);

  // reference routing from one field keeps pin and feed in step
  always_comb begin
    analog_ctrl.pin_is_port   = cur_ff.ctrl.reference_sel == SDAC_REF_PORT;
    analog_ctrl.ext_ref_sel   = cur_ff.ctrl.reference_sel == SDAC_REF_EXT;
    analog_ctrl.shared_pin_oe = cur_ff.ctrl.reference_sel[1];
    analog_ctrl.int_ref_sel   = cur_ff.ctrl.reference_sel == SDAC_REF_BOTH;
    analog_ctrl.gain_sel      = cur_ff.ctrl.gain_sel;
    analog_ctrl.channel_sel   = cur_ff.start[5:4];
    analog_ctrl.gain_bypass   = cur_ff.start[3];
    analog_ctrl.modulator_run = cur_ff.state == SDAC_CONV;
  end

endmodule

// File: testbench/sdac_core_asserts.sv
// checker: port-level properties of the converter control block
`timescale 1ns/1ps
module sdac_core_asserts
  import sdac_pkg::*;
(
  input wire logic         clk_sys,     // system clock
  input wire logic         rst,         // sync reset
  input wire logic [15:0]  reg_addr,    // register address
  input wire logic [15:0]  reg_wdata,   // write data
  input wire logic         reg_wr,      // write strobe
  input wire logic         reg_rd,      // read strobe
  input wire logic [15:0]  reg_rdata,   // read data
  input wire logic         low_power,   // low-power entry
  input wire sdac_analog_t analog_ctrl, // analog controls
  input wire logic         ovs_tick,    // oversample enable
  input wire logic         irq          // level interrupt
);
  logic [7:0] ctrl_ff; // shadow of the control register
  logic       mask_ff; // shadow of the end-of-conversion enable
  // shadows follow bus writes, so no design internals are needed
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_ff <= SDAC_CTRL_RST;
      mask_ff <= SDAC_MASK_RST[0];
    end else if (reg_wr && reg_addr == SDAC_ADDR_CTRL) begin
      ctrl_ff <= reg_wdata[7:0];
    end else if (reg_wr && reg_addr == SDAC_ADDR_IRQ_MK) begin
      mask_ff <= reg_wdata[0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_ref_pin_role: assert property (
    analog_ctrl.pin_is_port == (ctrl_ff[3:2] == SDAC_REF_PORT) &&
    analog_ctrl.ext_ref_sel == (ctrl_ff[3:2] == SDAC_REF_EXT))
    else $error("shared pin role differs from reference field");
  chk_ref_both_feed: assert property (
    analog_ctrl.int_ref_sel == (ctrl_ff[3:2] == SDAC_REF_BOTH) &&
    analog_ctrl.shared_pin_oe == ctrl_ff[3])
    else $error("internal reference routing differs from field");
  chk_gain_code: assert property (analog_ctrl.gain_sel == ctrl_ff[1:0])
    else $error("gain code differs from control register");
  chk_irq_masked: assert property (!mask_ff |-> !irq)
    else $error("interrupt high while disabled");
  chk_result_lsbs: assert property (
    reg_rd && reg_addr == SDAC_ADDR_RESULT |=> reg_rdata[1:0] == 2'h0)
    else $error("result low bits not zero");
  chk_ctrl_readback: assert property (
    reg_rd && reg_addr == SDAC_ADDR_CTRL |=>
    reg_rdata[7:0] == $past(ctrl_ff)) else $error("control readback");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("read data outside its cycle");
  chk_div_spacing: assert property (
    ovs_tick && ctrl_ff[6:4] != 3'h0 && !reg_wr |=> !ovs_tick)
    else $error("back-to-back ticks with divider set");
  chk_lp_halts: assert property (low_power[*3] |-> !ovs_tick)
    else $error("sampling continues in low power");
  chk_repeat_runs: assert property (
    (ctrl_ff[7] && ctrl_ff[6:4] == 3'h0 && !low_power)[*8] |->
    ##[0:8] ovs_tick) else $error("repeating mode stalled");
endmodule
bind sdac_core sdac_core_asserts chk_u (.clk_sys(clk_sys), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .low_power(low_power),
  .analog_ctrl(analog_ctrl), .ovs_tick(ovs_tick), .irq(irq));

// File: testbench/tb_sdac_core.sv
// testbench: register-level tests of the converter control block
`timescale 1ns/1ps
module tb_sdac_core;
  import sdac_pkg::*;
  logic         clk_sys, rst, reg_wr, reg_rd, low_power, filter_valid;
  logic [15:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic [13:0]  filter_data;
  logic         ovs_tick, irq;
  sdac_analog_t analog_ctrl;
  int           failures, checks, n, g;
  // short conversions keep the run brief
  sdac_core #(.CONV_OVS(4)) dut_u (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .low_power(low_power),
    .filter_valid(filter_valid), .filter_data(filter_data),
    .analog_ctrl(analog_ctrl), .ovs_tick(ovs_tick), .irq(irq));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one-cycle strobes, driven just after the rising edge
  task automatic wr(input logic [15:0] a, w);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
  // bounded wait on the tick (sel 0) or the interrupt (sel 1)
  task automatic wait_on(input bit sel, input int lim);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (n > lim) begin
        failures++;
        tally_and_finish;
      end
    end while ((sel ? irq : ovs_tick) !== 1'b1);
  endtask
  task automatic count_ticks(input int cyc);
    g = 0;
    repeat (cyc) begin
      @(negedge clk_sys);
      if (ovs_tick === 1'b1) g++;
    end
  endtask
  initial begin
    {rst, reg_wr, reg_rd, low_power, filter_valid} = 5'h10;
    {reg_addr, reg_wdata} = 32'h0;
    filter_data = 14'h2a5f;
    failures = 0;
    checks = 0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(SDAC_ADDR_CTRL);
    chk("ctrl_rst", d, {8'h0, SDAC_CTRL_RST});
    rd(SDAC_ADDR_IRQ_MK);
    chk("mask_rst", d, {14'h0, SDAC_MASK_RST});
    rd(16'hf063);
    chk("unmapped", d, 16'h0);
    wr(SDAC_ADDR_BGR, 16'h1);
    rd(SDAC_ADDR_BGR);
    chk("bg_run", d, 16'h1);
    for (int i = 0; i < 4; i++) begin
      wr(SDAC_ADDR_CTRL, 16'(i * 5));
      @(negedge clk_sys);
      chk("pin_port", 16'(analog_ctrl.pin_is_port), 16'(i == 0));
      chk("ext_ref", 16'(analog_ctrl.ext_ref_sel), 16'(i == 1));
      chk("int_ref", 16'(analog_ctrl.int_ref_sel), 16'(i == 3));
      chk("pin_oe", 16'(analog_ctrl.shared_pin_oe), 16'(i > 1));
      chk("gain", 16'(analog_ctrl.gain_sel), 16'(i));
    end
    // divider codes 0 to 6, prohibited code 6 included
    for (int c = 0; c < 7; c++) begin
      wr(SDAC_ADDR_CTRL, 16'(c << 4));
      // clear stale status so the interrupt wait sees this conversion end
      wr(SDAC_ADDR_IRQ_ST, 16'h3);
      wr(SDAC_ADDR_START, 16'h0090);
      wait_on(1'b0, 100);
      wait_on(1'b0, 64);
      chk("tick_gap", 16'(n), 16'(1 << (c > 5 ? 5 : c)));
      wait_on(1'b1, 200);
      rd(SDAC_ADDR_IRQ_ST);
      chk("status", d, c > 5 ? 16'h3 : 16'h1);
    end
    wr(SDAC_ADDR_CTRL, 16'h0050);
    wr(SDAC_ADDR_IRQ_ST, 16'h3);
    // early end by the decimator, then masking and a write to the result
    wr(SDAC_ADDR_START, 16'h0090);
    rd(SDAC_ADDR_START);
    chk("active", 16'(d[6]), 16'h1);
    filter_valid <= 1'b1;
    @(posedge clk_sys);
    filter_valid <= 1'b0;
    rd(SDAC_ADDR_START);
    chk("idle", 16'(d[6]), 16'h0);
    rd(SDAC_ADDR_RESULT);
    chk("result", d, {14'h2a5f, 2'h0});
    chk("irq_on", 16'(irq), 16'h1);
    wr(SDAC_ADDR_IRQ_MK, 16'h0);
    @(negedge clk_sys);
    chk("irq_masked", 16'(irq), 16'h0);
    wr(SDAC_ADDR_RESULT, 16'hffff);
    rd(SDAC_ADDR_RESULT);
    chk("result_ro", d, {14'h2a5f, 2'h0});
    wr(SDAC_ADDR_IRQ_MK, 16'h1);
    // repeating mode, stopped by clearing the mode, then by low power
    wr(SDAC_ADDR_CTRL, 16'h0080);
    count_ticks(40);
    chk("repeats", 16'(g > 8), 16'h1);
    wr(SDAC_ADDR_CTRL, 16'h0000);
    count_ticks(10);
    count_ticks(20);
    chk("mode_stop", 16'(g), 16'h0);
    wr(SDAC_ADDR_CTRL, 16'h0080);
    low_power <= 1'b1;
    count_ticks(3);
    count_ticks(20);
    chk("lp_stop", 16'(g), 16'h0);
    tally_and_finish;
  end
endmodule
